// File: pkg/acl_regs.svh
// offsets, field positions, reset values and sizes of the rule-table access
`ifndef ACL_REGS_SVH
`define ACL_REGS_SVH

// host-side byte registers
`define ACL_ADDR_SEL 8'h6e
`define ACL_ADDR_OFS 8'h6f
`define ACL_ADDR_DATA 8'ha0

// indirect offsets behind the data window
`define ACL_OFS_MASK_HI 8'h10
`define ACL_OFS_MASK_LO 8'h11
`define ACL_OFS_CTRL 8'h12
`define ACL_OFS_RING 8'h13

// table select field and port range
`define ACL_TABLE_SEL 3'b010
`define ACL_PORT_FIRST 4'h1
`define ACL_PORT_LAST 4'h5
`define ACL_PORTS 5
`define ACL_ENTRIES 16
`define ACL_ENTRY_BYTES 14
`define ACL_LAST_BYTE 4'hd

// entry_transfer_control fields
`define ACL_CTRL_WR_DONE_BIT 6
`define ACL_CTRL_RD_DONE_BIT 5
`define ACL_CTRL_DIR_BIT 4

// reset values
`define ACL_MASK_RESET 14'h0000
`define ACL_IDX_RESET 4'h0
`define ACL_DIR_RESET 1'b0
`define ACL_DONE_RESET 1'b1
`define ACL_RING_RESET 1'b0

`endif

// File: pkg/acl_pkg.sv
// types shared by the rule-table indirect access logic
package acl_pkg;
`include "acl_regs.svh"

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } host_req_t;

    typedef logic [`ACL_ENTRY_BYTES-1:0][7:0] entry_t;

    typedef enum logic [0:0] {XF_IDLE, XF_MOVE} xfer_state_t;

    typedef struct packed {
        xfer_state_t st;
        logic [3:0] step;
    } xfer_t;

    typedef struct packed {
        logic [7:0] sel;
        logic [7:0] ofs;
        logic [7:0] rdata;
        logic [`ACL_PORTS-1:0][13:0] mask;
        logic [`ACL_PORTS-1:0][3:0] idx;
        logic [`ACL_PORTS-1:0] dir;
        logic [`ACL_PORTS-1:0] wr_done;
        logic [`ACL_PORTS-1:0] rd_done;
        logic [`ACL_PORTS-1:0] ring;
        logic [2:0] xport;
        logic [3:0] xidx;
        logic xdir;
        entry_t [`ACL_PORTS-1:0] hold;
        entry_t [`ACL_PORTS-1:0][`ACL_ENTRIES-1:0] tbl;
    } core_t;
endpackage

// File: src/entry_xfer_seq.sv
// byte sequencer walking the 14 bytes of one table entry
`timescale 1ns/1ps
`include "acl_regs.svh"
module entry_xfer_seq (
    // clock and reset
    input logic ref_clk_i,
    input logic reset_n_i,
    // control
    input logic start_i,
    output logic busy_o,
    output logic done_o,
    // byte walk
    output logic step_valid_o,
    output logic [3:0] step_o
);
    import acl_pkg::*;

    xfer_t s_r;
    xfer_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        case (s_r.st)
            XF_IDLE: begin
                if (start_i) begin
                    s_nxt.st = XF_MOVE;
                    s_nxt.step = 4'h0;
                end
            end
            XF_MOVE: begin
                if (s_r.step == `ACL_LAST_BYTE) begin
                    s_nxt.st = XF_IDLE;
                end else begin
                    s_nxt.step = s_r.step + 4'h1;
                end
            end
            default: s_nxt.st = XF_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_r <= '{st: XF_IDLE, step: 4'h0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy_o = (s_r.st == XF_MOVE);
    assign step_valid_o = busy_o;
    assign step_o = s_r.step;
    assign done_o = busy_o && (s_r.step == `ACL_LAST_BYTE);

    AST_SEQ_SPAN: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (start_i && !busy_o) |=> busy_o ##13 done_o ##1 !busy_o)
        else $error("entry walk did not take fourteen cycles");
endmodule

// File: src/acl_entry_indirect_access.sv
// per-port indirect access to the 16-entry filtering rule table
`timescale 1ns/1ps
`include "acl_regs.svh"
module acl_entry_indirect_access (
    // clock and reset
    input logic ref_clk_i,
    input logic reset_n_i,
    // host byte register port
    input acl_pkg::host_req_t host_req_i,
    output logic [7:0] host_rdata_o,
    // filtering engine controls
    output logic [`ACL_PORTS-1:0] ring_single_miss_o,
    output logic xfer_busy_o
);
    import acl_pkg::*;

    core_t r;
    core_t n;
    logic busy;
    logic done;
    logic step_v;
    logic [3:0] step;
    logic start;
    logic busy_r;

    function automatic logic sel_ok(logic [7:0] sel);
        return (sel[7:5] == `ACL_TABLE_SEL) &&
            (sel[3:0] >= `ACL_PORT_FIRST) && (sel[3:0] <= `ACL_PORT_LAST);
    endfunction

    function automatic logic [2:0] sel_port(logic [7:0] sel);
        logic [3:0] p;
        p = sel[3:0] - `ACL_PORT_FIRST;
        return p[2:0];
    endfunction

    // reversed byte order: mask bit 13 is entry byte 0
    function automatic logic [3:0] mask_bit(logic [3:0] byte_ofs);
        return `ACL_LAST_BYTE - byte_ofs;
    endfunction

    function automatic logic [7:0] window(core_t s);
        logic [2:0] p;
        logic [7:0] v;
        p = sel_port(s.sel);
        v = 8'h00;
        if (sel_ok(s.sel)) begin
            if (s.ofs <= {4'h0, `ACL_LAST_BYTE}) begin
                v = s.hold[p][s.ofs[3:0]];
            end else if (s.ofs == `ACL_OFS_MASK_HI) begin
                v = {2'b00, s.mask[p][13:8]};
            end else if (s.ofs == `ACL_OFS_MASK_LO) begin
                v = s.mask[p][7:0];
            end else if (s.ofs == `ACL_OFS_CTRL) begin
                v = {1'b0, s.wr_done[p], s.rd_done[p], s.dir[p],
                    s.idx[p]};
            end else if (s.ofs == `ACL_OFS_RING) begin
                v = {7'h00, s.ring[p]};
            end
        end
        return v;
    endfunction

    wire [2:0] hp = sel_port(r.sel);
    wire hsel = sel_ok(r.sel);
    wire data_wr = host_req_i.wr && (host_req_i.addr == `ACL_ADDR_DATA)
        && hsel;
    // a second start while a walk runs is dropped; the host must poll first
    assign start = data_wr && (r.ofs == `ACL_OFS_CTRL) && !busy;

    entry_xfer_seq u_seq (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .start_i(start),
        .busy_o(busy),
        .done_o(done),
        .step_valid_o(step_v),
        .step_o(step)
    );

    wire [3:0] mb = mask_bit(step);
    wire en = r.mask[r.xport][mb];

    always_comb begin
        n = r;
        if (host_req_i.rd) begin
            case (host_req_i.addr)
                `ACL_ADDR_SEL: n.rdata = r.sel;
                `ACL_ADDR_OFS: n.rdata = r.ofs;
                `ACL_ADDR_DATA: n.rdata = window(r);
                default: n.rdata = 8'h00;
            endcase
        end
        if (host_req_i.wr && host_req_i.addr == `ACL_ADDR_SEL) begin
            n.sel = host_req_i.wdata;
        end
        if (host_req_i.wr && host_req_i.addr == `ACL_ADDR_OFS) begin
            n.ofs = host_req_i.wdata;
        end
        if (data_wr) begin
            if (r.ofs <= {4'h0, `ACL_LAST_BYTE}) begin
                n.hold[hp][r.ofs[3:0]] = host_req_i.wdata;
            end else if (r.ofs == `ACL_OFS_MASK_HI) begin
                n.mask[hp][13:8] = host_req_i.wdata[5:0];
            end else if (r.ofs == `ACL_OFS_MASK_LO) begin
                n.mask[hp][7:0] = host_req_i.wdata;
            end else if (r.ofs == `ACL_OFS_RING) begin
                n.ring[hp] = host_req_i.wdata[0];
            end
        end
        if (start) begin
            n.idx[hp] = host_req_i.wdata[3:0];
            n.dir[hp] = host_req_i.wdata[`ACL_CTRL_DIR_BIT];
            n.xport = hp;
            n.xidx = host_req_i.wdata[3:0];
            n.xdir = host_req_i.wdata[`ACL_CTRL_DIR_BIT];
            if (host_req_i.wdata[`ACL_CTRL_DIR_BIT]) begin
                n.wr_done[hp] = 1'b0;
            end else begin
                n.rd_done[hp] = 1'b0;
            end
        end
        // one byte per cycle; disabled bytes are skipped on both sides
        if (step_v && en) begin
            if (r.xdir) begin
                n.tbl[r.xport][r.xidx][step] = r.hold[r.xport][step];
            end else begin
                n.hold[r.xport][step] = r.tbl[r.xport][r.xidx][step];
            end
        end
        if (done) begin
            if (r.xdir) begin
                n.wr_done[r.xport] = 1'b1;
            end else begin
                n.rd_done[r.xport] = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            r <= '0;
            r.mask <= {`ACL_PORTS{`ACL_MASK_RESET}};
            r.idx <= {`ACL_PORTS{`ACL_IDX_RESET}};
            r.dir <= {`ACL_PORTS{`ACL_DIR_RESET}};
            r.wr_done <= {`ACL_PORTS{`ACL_DONE_RESET}};
            r.rd_done <= {`ACL_PORTS{`ACL_DONE_RESET}};
            r.ring <= {`ACL_PORTS{`ACL_RING_RESET}};
            busy_r <= 1'b0;
        end else begin
            r <= n;
            busy_r <= busy || start;
        end
    end

    assign host_rdata_o = r.rdata;
    assign ring_single_miss_o = r.ring;
    assign xfer_busy_o = busy_r;

    // helper views for the checks below
    wire [7:0] tbl_now = r.tbl[r.xport][r.xidx][step];
    wire [7:0] tbl_nxt = n.tbl[r.xport][r.xidx][step];
    wire [7:0] hold_now = r.hold[r.xport][step];
    wire [7:0] hold_nxt = n.hold[r.xport][step];

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    AST_WR_DONE_TIMING: assert property ((start && host_req_i.wdata[4])
        |=> !r.wr_done[r.xport] [*8] ##6 !r.wr_done[r.xport]
        ##1 r.wr_done[r.xport])
        else $error("write-complete flag timing wrong");
    AST_RD_DONE_TIMING: assert property ((start && !host_req_i.wdata[4])
        |=> !r.rd_done[r.xport] [*8] ##6 !r.rd_done[r.xport]
        ##1 r.rd_done[r.xport])
        else $error("read-complete flag timing wrong");
    AST_CTRL_FIELDS: assert property (start
        |=> r.idx[hp] == $past(host_req_i.wdata[3:0])
        && r.dir[hp] == $past(host_req_i.wdata[4]))
        else $error("index or direction not captured");
    AST_MASK_HI_ZERO: assert property ((host_req_i.rd
        && host_req_i.addr == `ACL_ADDR_DATA && r.ofs == `ACL_OFS_MASK_HI)
        |=> host_rdata_o[7:6] == 2'b00)
        else $error("mask high reserved bits not zero");
    AST_WR_SKIP: assert property ((step_v && r.xdir && !en)
        |-> tbl_nxt == tbl_now)
        else $error("disabled entry byte was written");
    AST_WR_COPY: assert property ((step_v && r.xdir && r.mask[r.xport][13]
        && step == 4'h0) |=> $past(hold_now) == r.tbl[r.xport][r.xidx][0])
        else $error("mask bit 13 did not move byte 0");
    AST_RD_SKIP: assert property ((step_v && !r.xdir && !en)
        |-> hold_nxt == hold_now)
        else $error("disabled holding byte was loaded");
    AST_RING_BIT: assert property ((data_wr && r.ofs == `ACL_OFS_RING)
        |=> ring_single_miss_o[hp] == $past(host_req_i.wdata[0]))
        else $error("ring miss control not stored");
    AST_BAD_SEL: assert property ((host_req_i.wr && !hsel
        && host_req_i.addr == `ACL_ADDR_DATA && !busy)
        |=> $stable(r.hold) && $stable(r.mask) && $stable(r.ring))
        else $error("write through unselected table changed state");
    AST_HOLD_WRITE: assert property ((data_wr && r.ofs < 8'h0e)
        |=> r.hold[hp][r.ofs[3:0]] == $past(host_req_i.wdata)
        || $past(step_v))
        else $error("holding byte not written through window");
    AST_CTRL_REFUSED: assert property ((data_wr && busy
        && r.ofs == `ACL_OFS_CTRL) |=> $stable(r.idx) && $stable(r.dir))
        else $error("control write accepted during a transfer");
endmodule

// File: testbench/host_model.sv
// host model issuing byte register accesses to the rule-table block
`timescale 1ns/1ps
`include "acl_regs.svh"
module host_model (
    // clock
    input wire logic ref_clk_i,
    // byte register port
    input wire logic [7:0] host_rdata_i,
    output acl_pkg::host_req_t host_req_o
);
    import acl_pkg::*;

    initial host_req_o = '0;

    // strobe lasts one cycle, then an idle cycle before the next access
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        host_req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk_i);
        host_req_o <= '0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        host_req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge ref_clk_i);
        host_req_o <= '0;
        #1 d = host_rdata_i;
    endtask

    task automatic point(input logic [3:0] p, input logic [7:0] o);
        wr(`ACL_ADDR_SEL, {`ACL_TABLE_SEL, 1'b0, p});
        wr(`ACL_ADDR_OFS, o);
    endtask

    task automatic wr_ind(input logic [3:0] p, input logic [7:0] o,
                          input logic [7:0] d);
        point(p, o);
        wr(`ACL_ADDR_DATA, d);
    endtask

    task automatic rd_ind(input logic [3:0] p, input logic [7:0] o,
                          output logic [7:0] d);
        point(p, o);
        rd(`ACL_ADDR_DATA, d);
    endtask

    // bounded wait on a done flag before the next step
    task automatic poll(input logic [3:0] p, input int b, output logic ok);
        logic [7:0] d;
        ok = 1'b0;
        point(p, `ACL_OFS_CTRL);
        for (int i = 0; i < 40 && !ok; i++) begin
            rd(`ACL_ADDR_DATA, d);
            ok = (d[b] === 1'b1);
        end
    endtask
endmodule

// File: testbench/test_acl_entry_indirect_access.sv
// self-checking bench for the rule-table indirect access block
`timescale 1ns/1ps
`include "acl_regs.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
module test_acl_entry_indirect_access;
    import acl_pkg::*;
    logic ref_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    host_req_t host_req;
    logic [7:0] host_rdata;
    logic [`ACL_PORTS-1:0] ring;
    logic busy;
    int errors = 0;
    int checks = 0;

    always #2.5 ref_clk_i = ~ref_clk_i;

    acl_entry_indirect_access uut (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .host_req_i(host_req),
        .host_rdata_o(host_rdata),
        .ring_single_miss_o(ring),
        .xfer_busy_o(busy)
    );

    host_model host (
        .ref_clk_i(ref_clk_i),
        .host_rdata_i(host_rdata),
        .host_req_o(host_req)
    );

    task automatic close_out;
        if (errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic t_reset;
        logic [7:0] d;
        `CHK("ring_out", 5'h00, ring)
        host.rd_ind(4'h1, `ACL_OFS_MASK_HI, d);
        `CHK("mask_hi", 8'h00, d)
        host.rd_ind(4'h1, `ACL_OFS_MASK_LO, d);
        `CHK("mask_lo", 8'h00, d)
        host.rd_ind(4'h1, `ACL_OFS_CTRL, d);
        `CHK("ctrl", 8'h60, d)
        host.rd_ind(4'h1, `ACL_OFS_RING, d);
        `CHK("ring_reg", 8'h00, d)
    endtask

    task automatic t_mask_sel;
        logic [7:0] d;
        host.wr_ind(4'h3, `ACL_OFS_MASK_HI, 8'hff);
        host.rd_ind(4'h3, `ACL_OFS_MASK_HI, d);
        `CHK("mask_hi", 8'h3f, d)
        host.wr_ind(4'h3, `ACL_OFS_MASK_LO, 8'ha5);
        // port 0 is outside the legal range, so the window is dead
        host.wr_ind(4'h0, `ACL_OFS_MASK_LO, 8'h77);
        host.rd(`ACL_ADDR_DATA, d);
        `CHK("bad_port", 8'h00, d)
        host.rd_ind(4'h3, `ACL_OFS_MASK_LO, d);
        `CHK("mask_lo", 8'ha5, d)
        host.rd(`ACL_ADDR_OFS, d);
        `CHK("offset", `ACL_OFS_MASK_LO, d)
        host.rd(8'h55, d);
        `CHK("unmapped", 8'h00, d)
        host.wr_ind(4'h2, `ACL_OFS_RING, 8'hff);
        // let the edge that takes the write update the output first
        @(negedge ref_clk_i);
        `CHK("ring_out", 5'h02, ring)
        host.rd(`ACL_ADDR_DATA, d);
        `CHK("ring_reg", 8'h01, d)
    endtask

    // odd bytes written into entry 15, then the whole entry read back
    task automatic t_xfer;
        logic [7:0] d;
        logic ok;
        for (int k = 0; k < 14; k++) begin
            host.wr_ind(4'h5, 8'(k), 8'(k + 1));
        end
        host.wr_ind(4'h5, `ACL_OFS_MASK_HI, 8'h15);
        host.wr_ind(4'h5, `ACL_OFS_MASK_LO, 8'h55);
        host.wr_ind(4'h5, `ACL_OFS_CTRL, 8'h1f);
        host.rd_ind(4'h5, `ACL_OFS_CTRL, d);
        `CHK("ctrl_wr", 8'h3f, d)
        `CHK("busy", 1'b1, busy)
        host.poll(4'h5, `ACL_CTRL_WR_DONE_BIT, ok);
        if (!ok) begin
            errors++;
            close_out();
        end
        `CHK("busy_end", 1'b0, busy)
        for (int k = 0; k < 14; k++) begin
            host.wr_ind(4'h5, 8'(k), 8'h00);
        end
        host.wr_ind(4'h5, `ACL_OFS_MASK_HI, 8'h3f);
        host.wr_ind(4'h5, `ACL_OFS_MASK_LO, 8'hff);
        host.wr_ind(4'h5, `ACL_OFS_CTRL, 8'h0f);
        // a second start while the walk runs must be dropped
        host.wr(`ACL_ADDR_DATA, 8'h13);
        host.rd_ind(4'h5, `ACL_OFS_CTRL, d);
        `CHK("ctrl_rd", 8'h4f, d)
        host.poll(4'h5, `ACL_CTRL_RD_DONE_BIT, ok);
        if (!ok) begin
            errors++;
            close_out();
        end
        host.rd(`ACL_ADDR_DATA, d);
        `CHK("ctrl_done", 8'h6f, d)
        for (int k = 0; k < 14; k++) begin
            host.rd_ind(4'h5, 8'(k), d);
            `CHK("entry", (k % 2) ? 8'(k + 1) : 8'h00, d)
        end
        // only byte 13 enabled: the read must leave byte 0 alone
        host.wr_ind(4'h5, 8'h00, 8'hcc);
        host.wr_ind(4'h5, 8'h0d, 8'hdd);
        host.wr_ind(4'h5, `ACL_OFS_MASK_HI, 8'h00);
        host.wr_ind(4'h5, `ACL_OFS_MASK_LO, 8'h01);
        host.wr_ind(4'h5, `ACL_OFS_CTRL, 8'h0f);
        host.poll(4'h5, `ACL_CTRL_RD_DONE_BIT, ok);
        if (!ok) begin
            errors++;
            close_out();
        end
        host.rd_ind(4'h5, 8'h00, d);
        `CHK("kept_byte", 8'hcc, d)
        host.rd_ind(4'h5, 8'h0d, d);
        `CHK("loaded_byte", 8'h0e, d)
    endtask

    initial begin
        repeat (8) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        t_reset();
        t_mask_sel();
        t_xfer();
        close_out();
    end
endmodule
